// ### common/sdpc_pkg.sv
// Constants and types shared by the serial resistor control block.
// Operation
// - Host shifts complete ten-bit words; device accepts.
// - Two address bits then eight code bits, MSB first.
// - Channel equals high bit times two plus low.
// - Channels updated one per word, any order.
// - Serial clock runs up to 10 MHz.
// - No power-up preset beyond the reset input.
// - Midscale reset sets every latch to 128.
// - Shutdown opens high ends, wipers to low ends.
// - Shutdown keeps latches; codes return afterwards.
// - Serial input works in shutdown; output disabled.
// - Codes written in shutdown apply after release.
// - Eight-bit code selects one of 256 taps.
// - Code zero nearest low end, 255 at top.
// - Each channel has its own independent latch.
// - Select low shifts one bit per rising clock.
// - Select rising edge decodes address, loads latch.
// - Latch receives the last eight shifted bits.
// - Midscale reset loads hexadecimal 80 into all four latches.
package sdpc_pkg;
    localparam int WORD_BITS = 10;
    localparam int CODE_BITS = 8;
    localparam int ADDR_BITS = 2;
    localparam int CHANNELS = 4;
    localparam int TAPS = 256;
    localparam int ADDR_HI_POS = 9;
    localparam int ADDR_LO_POS = 8;
    localparam int CODE_MSB_POS = 7;
    localparam int CODE_LSB_POS = 0;
    localparam logic [7:0] MIDSCALE_CODE = 8'h80;
    localparam logic [9:0] SHIFT_RESET = 10'h000;
    localparam int SCLK_MAX_MHZ = 10;
    localparam int REF_CLK_MHZ = 250;
    // Fewest reference cycles per serial clock half period at top speed.
    localparam int SCLK_HALF_CYCLES = REF_CLK_MHZ / (2 * SCLK_MAX_MHZ);
    typedef logic [7:0] sdpc_code_t;
    typedef logic [255:0] sdpc_taps_t;
endpackage

// ### common/sdpc_link_if.sv
// Synchronised serial pin events passed between the block's modules.
`timescale 1ns/1ns
`default_nettype none
interface sdpc_link_if;
    logic sclk_rise;
    logic sel_low;
    logic sel_rise;
    logic data;
    modport front (output sclk_rise, output sel_low, output sel_rise,
                   output data);
    modport core (input sclk_rise, input sel_low, input sel_rise,
                  input data);
endinterface
`default_nettype wire

// ### rtl/sdpc_pin_sync.sv
// Two-stage pin synchronisers and edge finders for the serial pins.
`timescale 1ns/1ns
`default_nettype none
module sdpc_pin_sync (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Raw serial pins.
    input wire logic sclk_i,
    input wire logic sel_n_i,
    input wire logic serial_in_pin_i,
    // Events towards the shift logic.
    sdpc_link_if.front link
);
    logic [2:0] sclk_r;
    logic [2:0] sel_r;
    logic [1:0] din_r;

    // Stage one feeds only stage two; stage three finds edges.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_r <= 3'h0;
            sel_r <= 3'h7;
            din_r <= 2'h0;
        end else begin
            sclk_r <= {sclk_r[1:0], sclk_i};
            sel_r <= {sel_r[1:0], sel_n_i};
            din_r <= {din_r[0], serial_in_pin_i};
        end
    end

    // Data is taken on the same synchronised edge as the clock.
    assign link.sclk_rise = sclk_r[1] & ~sclk_r[2];
    assign link.sel_low = ~sel_r[1];
    assign link.sel_rise = sel_r[1] & ~sel_r[2];
    assign link.data = din_r[1];
endmodule
`default_nettype wire

// ### rtl/sdpc_tap_decode.sv
// One-hot decoder from an eight-bit code to one of 256 taps.
`timescale 1ns/1ns
`default_nettype none
module sdpc_tap_decode (
    // Code in.
    input wire sdpc_pkg::sdpc_code_t code_i,
    // One-hot tap select, bit 0 nearest the low end.
    output logic [sdpc_pkg::TAPS-1:0] taps_o
);
    // Each tap bit compares against its own index.
    for (genvar t = 0; t < sdpc_pkg::TAPS; t++) begin : g_tap
        assign taps_o[t] = (code_i == 8'(t));
    end
endmodule
`default_nettype wire

// ### rtl/sdpc_top.sv
// Serial controlled four-channel resistor code latches and tap select.
`timescale 1ns/1ns
`default_nettype none
module sdpc_top (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Serial link pins.
    input wire logic sclk_i,
    input wire logic sel_n_i,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_o,
    // Control pins.
    input wire logic midscale_reset_n_i,
    input wire logic power_down_n_i,
    // Channel state.
    output logic [31:0] resistor_code_latch_o,
    output logic [3:0] high_end_open_o,
    output logic [3:0] wiper_to_low_o,
    output logic [1023:0] wiper_tap_o
);
    sdpc_link_if link ();
    logic [9:0] shift_r;
    logic [9:0] shift_nxt;
    logic [31:0] latch_r;
    logic [1:0] mrst_r;
    logic [1:0] pdn_r;
    logic [1023:0] taps;
    logic out_bit_r;

    sdpc_pin_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .sclk_i(sclk_i),
        .sel_n_i(sel_n_i),
        .serial_in_pin_i(serial_in_pin_i),
        .link(link)
    );

    // Control pins pass two flip-flops; the result acts as a level.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mrst_r <= 2'h0;
            pdn_r <= 2'h0;
        end else begin
            mrst_r <= {mrst_r[0], midscale_reset_n_i};
            pdn_r <= {pdn_r[0], power_down_n_i};
        end
    end

    // Shift in MSB first while select is low, one bit per clock rise.
    always_comb begin
        shift_nxt = shift_r;
        if (link.sel_low && link.sclk_rise) begin
            shift_nxt = {shift_r[8:0], link.data};
        end
    end

    // Shift register; a midscale reset clears it along with the output.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_r <= sdpc_pkg::SHIFT_RESET;
        end else if (!mrst_r[1]) begin
            shift_r <= sdpc_pkg::SHIFT_RESET;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // Serial output holds the bit leaving the tenth stage.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_bit_r <= 1'b0;
        end else if (!mrst_r[1]) begin
            out_bit_r <= 1'b0;
        end else if (link.sel_low && link.sclk_rise) begin
            out_bit_r <= shift_r[sdpc_pkg::ADDR_HI_POS];
        end
    end

    // Open drain driver: pull low for a zero, released in shutdown.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_out_pin_o <= 1'b0;
            serial_out_pin_oe_o <= 1'b0;
        end else begin
            serial_out_pin_o <= 1'b0;
            serial_out_pin_oe_o <= pdn_r[1] && !out_bit_r;
        end
    end

    // Per-channel latches, loaded on select rising; reset wins.
    for (genvar c = 0; c < sdpc_pkg::CHANNELS; c++) begin : g_ch
        always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                latch_r[c*8 +: 8] <= sdpc_pkg::MIDSCALE_CODE;
            end else if (!mrst_r[1]) begin
                latch_r[c*8 +: 8] <= sdpc_pkg::MIDSCALE_CODE;
            end else if (link.sel_rise &&
                         shift_r[9:8] == 2'(c)) begin
                latch_r[c*8 +: 8] <= shift_r[7:0];
            end
        end

        sdpc_tap_decode u_dec (
            .code_i(latch_r[c*8 +: 8]),
            .taps_o(taps[c*256 +: 256])
        );

        // Shutdown forces wiper low and opens high end; latch kept.
        always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                high_end_open_o[c] <= 1'b1;
                wiper_to_low_o[c] <= 1'b1;
                wiper_tap_o[c*256 +: 256] <= 256'h1;
            end else begin
                high_end_open_o[c] <= !pdn_r[1];
                wiper_to_low_o[c] <= !pdn_r[1];
                wiper_tap_o[c*256 +: 256] <= pdn_r[1] ?
                    taps[c*256 +: 256] : 256'h1;
            end
        end
    end

    // Latch contents shown to the outside.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            resistor_code_latch_o <=
                {sdpc_pkg::CHANNELS{sdpc_pkg::MIDSCALE_CODE}};
        end else begin
            resistor_code_latch_o <= latch_r;
        end
    end
endmodule
`default_nettype wire

// ### tb/sdpc_host_model.sv
// Host model that shifts ten-bit words into the serial pins.
`timescale 1ns/1ns
`default_nettype none
module sdpc_host_model (
    // Reference clock used for pacing.
    input wire logic ref_clk_i,
    // Serial pins towards the block.
    output logic sclk_o,
    output logic sel_n_o,
    output logic serial_in_pin_o
);
    // The clock idles low between frames.
    initial begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        serial_in_pin_o = 1'b0;
    end
    // Sends one word with four reference cycles per clock phase.
    task automatic send(input logic [9:0] w);
        sel_n_o = 1'b0;
        for (int i = 9; i >= 0; i--) begin
            serial_in_pin_o = w[i];
            repeat (4) @(negedge ref_clk_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge ref_clk_i);
            sclk_o = 1'b0;
        end
        sel_n_o = 1'b1;
        // Released data never shows the last bit.
        serial_in_pin_o = ~serial_in_pin_o;
        repeat (10) @(negedge ref_clk_i);
    endtask
endmodule
`default_nettype wire

// ### tb/sdpc_top_chk.sv
// Concurrent checks on the ports of the serial resistor block.
`timescale 1ns/1ns
`default_nettype none
module sdpc_top_chk (
    // Clock, reset and control pins.
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic sel_n_i,
    input wire logic midscale_reset_n_i,
    input wire logic power_down_n_i,
    // Block outputs.
    input wire logic serial_out_pin_oe_o,
    input wire logic [31:0] resistor_code_latch_o,
    input wire logic [3:0] high_end_open_o,
    input wire logic [3:0] wiper_to_low_o,
    input wire logic [1023:0] wiper_tap_o
);
    // Every check samples on the reference clock and idles in reset.
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Levels held past the synchronisers must show at the outputs.
    mid_codes_a: assert property (!midscale_reset_n_i [*5]
        |-> resistor_code_latch_o == 32'h80808080) else $error("not midscale");
    off_open_a: assert property (!power_down_n_i [*5]
        |-> {high_end_open_o, wiper_to_low_o} == 8'hff) else $error("not off");
    off_taps_a: assert property (!power_down_n_i [*5]
        |-> wiper_tap_o == {4{256'h1}}) else $error("wiper not at low end");
    off_sdo_a: assert property (!power_down_n_i [*5]
        |-> !serial_out_pin_oe_o) else $error("output driven in shutdown");
    on_open_a: assert property (power_down_n_i [*5]
        |-> {high_end_open_o, wiper_to_low_o} == 8'h00)
        else $error("still off");
    tap_low_a: assert property (power_down_n_i [*5]
        |-> wiper_tap_o[255:0] == 256'h1 << resistor_code_latch_o[7:0])
        else $error("channel 0 tap wrong");
    tap_high_a: assert property (power_down_n_i [*5]
        |-> wiper_tap_o[1023:768] == 256'h1 << resistor_code_latch_o[31:24])
        else $error("channel 3 tap wrong");
    latch_hold_a: assert property (
        (sel_n_i && midscale_reset_n_i) [*8]
        |-> $stable(resistor_code_latch_o))
        else $error("latch moved while idle");
endmodule
bind sdpc_top sdpc_top_chk sdpc_top_chk_inst (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .sel_n_i(sel_n_i),
    .midscale_reset_n_i(midscale_reset_n_i), .power_down_n_i(power_down_n_i),
    .serial_out_pin_oe_o(serial_out_pin_oe_o),
    .resistor_code_latch_o(resistor_code_latch_o),
    .high_end_open_o(high_end_open_o), .wiper_to_low_o(wiper_to_low_o),
    .wiper_tap_o(wiper_tap_o));
`default_nettype wire

// ### tb/sdpc_top_tb_top.sv
// Self-checking bench for the serial resistor block.
`timescale 1ns/1ns
`default_nettype none
module sdpc_top_tb_top;
    logic ref_clk_i, rst_n_i, mid_n, pdn_n, sclk, sel_n, ser_in;
    logic ser_out, ser_out_oe;
    logic [9:0] last_w;
    logic [31:0] codes;
    logic [3:0] hi_open, w_low;
    logic [1023:0] taps;
    sdpc_pkg::sdpc_code_t exp_c [4];
    int errors, cmp_count, seed;
    sdpc_host_model host_inst (.ref_clk_i(ref_clk_i), .sclk_o(sclk),
        .sel_n_o(sel_n), .serial_in_pin_o(ser_in));
    sdpc_top sdpc_top_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .sclk_i(sclk), .sel_n_i(sel_n), .serial_in_pin_i(ser_in),
        .serial_out_pin_o(ser_out), .serial_out_pin_oe_o(ser_out_oe),
        .midscale_reset_n_i(mid_n), .power_down_n_i(pdn_n),
        .resistor_code_latch_o(codes), .high_end_open_o(hi_open),
        .wiper_to_low_o(w_low), .wiper_tap_o(taps));
    // Expected one-hot taps, forced to the low end when shut down.
    function automatic logic [1023:0] tap_exp(input logic off);
        for (int c = 0; c < 4; c++) begin
            tap_exp[256*c +: 256] = off ? 256'h1 : 256'h1 << exp_c[c];
        end
    endfunction
    // Compares one result and counts it.
    task automatic chk(input string n, input logic [1023:0] e, g);
        cmp_count++;
        if (e !== g) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Compares all latches and taps with the expected state.
    task automatic check_all(input logic off);
        chk("latches", {exp_c[3], exp_c[2], exp_c[1], exp_c[0]},
            codes);
        chk("taps", tap_exp(off), taps);
    endtask
    // Writes one channel; the chain output carries bit 0 of the word sent before this one.
    task automatic put(input logic [1:0] a, input logic [7:0] d);
        host_inst.send({a, d});
        exp_c[a] = d;
        chk("chain", {pdn_n & ~last_w[0]}, ser_out_oe);
        chk("out_val", 1'b0, ser_out);
        last_w = {a, d};
    endtask
    // Prints the verdict and ends the run.
    task automatic summarize();
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        summarize();
    end
    // Main sequence: reset, corner codes, random words, shutdown, midscale.
    initial begin
        {rst_n_i, mid_n, pdn_n} = 3'h3;
        errors = 0;
        cmp_count = 0;
        seed = 41;
        last_w = 10'h000;
        for (int c = 0; c < 4; c++) exp_c[c] = 8'h80;
        repeat (6) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        check_all(1'b0);
        put(2'h0, 8'h00);
        put(2'h3, 8'hff);
        check_all(1'b0);
        for (int i = 0; i < 12; i++) begin
            put(2'($random(seed)), 8'($random(seed)));
            check_all(1'b0);
        end
        pdn_n = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        chk("off", 8'hff, {hi_open, w_low});
        chk("oe", 1'b0, ser_out_oe);
        put(2'h1, 8'h5a);
        check_all(1'b1);
        pdn_n = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        check_all(1'b0);
        chk("off", 8'h00, {hi_open, w_low});
        mid_n = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        for (int c = 0; c < 4; c++) exp_c[c] = 8'h80;
        last_w = 10'h000;
        check_all(1'b0);
        // A word sent while midscale is held must be ignored.
        host_inst.send({2'h2, 8'h33});
        check_all(1'b0);
        mid_n = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        put(2'h2, 8'h33);
        check_all(1'b0);
        summarize();
    end
endmodule
`default_nettype wire
